// ---- hdl/ucg_clock_ctrl.sv ----
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - 48 MHz usb clock while usb enabled in a primary pll mode
// - prescaler divides oscillator to 4 MHz
// - 96 MHz multiplier feeds both branches
// - usb branch divides by two
// - system branch divides by three, then divider
// - divide code gives 32/16/8/4 MHz
// - prescale codes divide by 1,2,3,4,5,6,10,12
// - only primary pll modes permit usb
// - other modes selectable, usb clock off
// - reference output works in every mode
// - bit 15 drives reference onto pin
// - bits 11:8 divide by two to power
// - bit 12 picks oscillator or system clock
// - bit 13 keeps reference running in sleep
// - bit 14 and 7:0 read zero
// - next oscillator accepted only when unlocked
module ucg_clock_ctrl #(
  parameter int CNT_W = 14
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucg_pkg::ADDR_W-1:0] paddr,
  input wire logic [ucg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ucg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator and system state
  input wire logic oscTick,
  input wire logic sysTick,
  input wire logic [2:0] oscMode,
  input wire logic usbEnable,
  input wire logic sleepMode,
  input wire logic configLock,
  input wire logic primaryOscKeepOn,
  // clock tree results
  output logic pllRefTick,
  output logic usbClkRun,
  output logic [5:0] sysClkMhz,
  output logic [4:0] sysDivRatio,
  output logic [2:0] nextOscSelect,
  output logic primaryOscRunInSleep,
  // reference output pin
  output logic refoutPin,
  output logic refoutPinOe
);
  import ucg_pkg::*;

  // software registers
  logic [15:0] refcon_q, refcon_d;
  logic [PRE_W-1:0] prescale_q, prescale_d;
  logic [SYSDIV_W-1:0] sysDiv_q, sysDiv_d;
  logic [NEXT_OSC_SELECT_W-1:0] nextOsc_q, nextOsc_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  // prescaler state
  logic [3:0] preCnt_q, preCnt_d;
  logic refTick_q, refTick_d;
  // derived outputs
  logic usbRun_q, usbRun_d;
  logic [5:0] mhz_q, mhz_d;
  logic [4:0] ratio_q, ratio_d;

  // decode and field views
  logic hitRef, hitCfg, hitSt, mapped, wrStrobe, rdSetup;
  logic refEn, refSlp, refSel, pllMode, refActive, baseTick;
  logic [REF_DIV_W-1:0] refDiv;
  logic [3:0] preFactor;
  logic [DATA_W-1:0] statusWord;

  assign hitRef = (paddr == OFS_REFCON);
  assign hitCfg = (paddr == OFS_PLLCFG);
  assign hitSt = (paddr == OFS_STATUS);
  assign mapped = hitRef | hitCfg | hitSt;
  assign wrStrobe = psel & penable & pwrite & mapped;
  assign rdSetup = psel & ~penable;

  // single-cycle access, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_q;

  assign refEn = refcon_q[REF_EN_BIT];
  assign refSlp = refcon_q[REF_SLP_BIT];
  assign refSel = refcon_q[REF_SEL_BIT];
  assign refDiv = refcon_q[REF_DIV_LSB +: REF_DIV_W];
  assign preFactor = ucg_pre_factor(prescale_q);

  // pll-based primary modes only; rc pll mode excluded
  assign pllMode = (oscMode == MODE_EXT_CLOCK_WITH_PLL) |
                   (oscMode == MODE_HIGH_SPEED_XTAL_PLL) |
                   (oscMode == MODE_STD_XTAL_PLL);

  // reference source choice, stopped in sleep unless asked
  assign baseTick = refSel ? oscTick : sysTick;
  assign refActive = refEn & (~sleepMode | refSlp);

  // oscillator stays powered in sleep only when configured
  assign primaryOscRunInSleep = primaryOscKeepOn | (refActive & refSel & sleepMode);

  // register writes
  always_comb begin
    refcon_d = refcon_q;
    prescale_d = prescale_q;
    sysDiv_d = sysDiv_q;
    nextOsc_d = nextOsc_q;
    if (wrStrobe && hitRef) begin
      if (pstrb[1]) begin
        refcon_d[15:8] = pwdata[15:8] & REFCON_WMASK[15:8];
      end
      refcon_d[7:0] = 8'h00;
    end
    if (wrStrobe && hitCfg) begin
      if (pstrb[0]) begin
        prescale_d = pwdata[PRE_LSB +: PRE_W];
        sysDiv_d = pwdata[SYSDIV_LSB +: SYSDIV_W];
      end
      if (pstrb[1] && !configLock) begin
        nextOsc_d = pwdata[NEXT_OSC_SELECT_LSB +: NEXT_OSC_SELECT_W];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      refcon_q <= REFCON_RESET;
      prescale_q <= PRE_RESET;
      sysDiv_q <= SYSDIV_RESET;
      nextOsc_q <= NEXT_OSC_SELECT_RESET;
    end else begin
      refcon_q <= refcon_d;
      prescale_q <= prescale_d;
      sysDiv_q <= sysDiv_d;
      nextOsc_q <= nextOsc_d;
    end
  end

  // status word assembly
  always_comb begin
    statusWord = '0;
    statusWord[ST_USB_BIT] = usbRun_q;
    statusWord[ST_PLLMODE_BIT] = pllMode;
    statusWord[ST_REFACT_BIT] = refActive;
    statusWord[ST_OSCON_BIT] = primaryOscRunInSleep;
    statusWord[ST_MHZ_LSB +: 6] = mhz_q;
    statusWord[ST_RATIO_LSB +: 5] = ratio_q;
    statusWord[ST_PRE_LSB +: 4] = preFactor;
  end

  // read data captured in the setup cycle
  always_comb begin
    rdata_d = rdata_q;
    if (rdSetup) begin
      rdata_d = '0;
      if (hitRef) begin
        rdata_d[15:0] = refcon_q & REFCON_WMASK;
      end else if (hitCfg) begin
        rdata_d[PRE_LSB +: PRE_W] = prescale_q;
        rdata_d[SYSDIV_LSB +: SYSDIV_W] = sysDiv_q;
        rdata_d[NEXT_OSC_SELECT_LSB +: NEXT_OSC_SELECT_W] = nextOsc_q;
      end else if (hitSt) begin
        rdata_d = statusWord;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // prescaler: one reference tick per factor oscillator ticks
  always_comb begin
    preCnt_d = preCnt_q;
    refTick_d = 1'b0;
    if (oscTick) begin
      if (preCnt_q >= preFactor - 4'h1) begin
        preCnt_d = 4'h0;
        refTick_d = 1'b1;
      end else begin
        preCnt_d = preCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      preCnt_q <= 4'h0;
      refTick_q <= 1'b0;
    end else begin
      preCnt_q <= preCnt_d;
      refTick_q <= refTick_d;
    end
  end

  assign pllRefTick = refTick_q;

  // branch dividers of the 96 MHz multiplier output
  always_comb begin
    usbRun_d = usbEnable & pllMode & (USB_CLK_MHZ != 0);
    ratio_d = 5'(SYS_BRANCH_DIV << sysDiv_q);
    mhz_d = 6'(SYS_TOP_MHZ >> sysDiv_q);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      usbRun_q <= 1'b0;
      ratio_q <= 5'h00;
      mhz_q <= 6'h00;
    end else begin
      usbRun_q <= usbRun_d;
      ratio_q <= ratio_d;
      mhz_q <= mhz_d;
    end
  end

  assign usbClkRun = usbRun_q;
  assign sysDivRatio = ratio_q;
  assign sysClkMhz = mhz_q;
  assign nextOscSelect = nextOsc_q;

  // reference divider drives the pin
  ucg_ref_div #(
    .DIV_W(REF_DIV_W),
    .CNT_W(CNT_W)
  ) uRefDiv (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(refActive),
    .baseTick(baseTick),
    .divCode(refDiv),
    .refOut(refoutPin)
  );

  assign refoutPinOe = refEn;

endmodule : ucg_clock_ctrl

// ---- include/ucg_pkg.sv ----
package ucg_pkg;

  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_REFCON = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PLLCFG = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;

  // reference clock output control fields
  localparam int REF_EN_BIT = 15;
  localparam int REF_SLP_BIT = 13;
  localparam int REF_SEL_BIT = 12;
  localparam int REF_DIV_LSB = 8;
  localparam int REF_DIV_W = 4;
  localparam logic [15:0] REFCON_RESET = 16'h0000;
  localparam logic [15:0] REFCON_WMASK = 16'hBF00;

  // pll configuration fields
  localparam int PRE_LSB = 0;
  localparam int PRE_W = 3;
  localparam int SYSDIV_LSB = 4;
  localparam int SYSDIV_W = 2;
  localparam int NEXT_OSC_SELECT_LSB = 8;
  localparam int NEXT_OSC_SELECT_W = 3;
  localparam logic [PRE_W-1:0] PRE_RESET = 3'h0;
  localparam logic [SYSDIV_W-1:0] SYSDIV_RESET = 2'h0;
  localparam logic [NEXT_OSC_SELECT_W-1:0] NEXT_OSC_SELECT_RESET = 3'h0;

  // status fields
  localparam int ST_USB_BIT = 0;
  localparam int ST_PLLMODE_BIT = 1;
  localparam int ST_REFACT_BIT = 2;
  localparam int ST_OSCON_BIT = 3;
  localparam int ST_MHZ_LSB = 8;
  localparam int ST_RATIO_LSB = 16;
  localparam int ST_PRE_LSB = 24;

  // oscillator mode codes seen on the mode input
  localparam logic [2:0] MODE_FAST_RC = 3'h0;
  localparam logic [2:0] MODE_INTERNAL_RC_WITH_PLL = 3'h1;
  localparam logic [2:0] MODE_EXT_CLOCK_WITH_PLL = 3'h2;
  localparam logic [2:0] MODE_HIGH_SPEED_XTAL_PLL = 3'h3;
  localparam logic [2:0] MODE_STD_XTAL_PLL = 3'h4;

  // clock tree figures in MHz
  localparam int PLL_REF_MHZ = 4;
  localparam int PLL_OUT_MHZ = 96;
  localparam int USB_BRANCH_DIV = 2;
  localparam int SYS_BRANCH_DIV = 3;
  localparam int USB_CLK_MHZ = PLL_OUT_MHZ / USB_BRANCH_DIV;
  localparam int SYS_TOP_MHZ = PLL_OUT_MHZ / SYS_BRANCH_DIV;

  // prescaler division factor per code
  localparam logic [3:0] PRE_F0 = 4'h1;
  localparam logic [3:0] PRE_F1 = 4'h2;
  localparam logic [3:0] PRE_F2 = 4'h3;
  localparam logic [3:0] PRE_F3 = 4'h4;
  localparam logic [3:0] PRE_F4 = 4'h5;
  localparam logic [3:0] PRE_F5 = 4'h6;
  localparam logic [3:0] PRE_F6 = 4'hA;
  localparam logic [3:0] PRE_F7 = 4'hC;

  function automatic logic [3:0] ucg_pre_factor(input logic [PRE_W-1:0] code);
    unique case (code)
      3'h0: ucg_pre_factor = PRE_F0;
      3'h1: ucg_pre_factor = PRE_F1;
      3'h2: ucg_pre_factor = PRE_F2;
      3'h3: ucg_pre_factor = PRE_F3;
      3'h4: ucg_pre_factor = PRE_F4;
      3'h5: ucg_pre_factor = PRE_F5;
      3'h6: ucg_pre_factor = PRE_F6;
      3'h7: ucg_pre_factor = PRE_F7;
    endcase
  endfunction : ucg_pre_factor

endpackage : ucg_pkg

// ---- hdl/ucg_ref_div.sv ----
`timescale 1ns/100ps
module ucg_ref_div #(
  parameter int DIV_W = 4,
  parameter int CNT_W = 14
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire logic baseTick,
  input wire logic [DIV_W-1:0] divCode,
  // divided output
  output logic refOut
);
  import ucg_pkg::*;

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic [CNT_W-1:0] halfLast;

  // last count of one half period, 2^(code-1) base ticks
  assign halfLast = (divCode == '0) ? '0 :
                    CNT_W'((32'h1 << (divCode - 1'b1)) - 32'h1);

  // next state of half-period counter and output
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!enable) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (divCode == '0) begin
      cnt_d = '0;
      out_d = baseTick;
    end else if (baseTick) begin
      if (cnt_q >= halfLast) begin
        cnt_d = '0;
        out_d = ~out_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign refOut = out_q;

endmodule : ucg_ref_div

// ---- testbench/ucg_ref_sink.sv ----
`timescale 1ns/100ps
module ucg_ref_sink (
  // clock
  input wire logic clk_sys,
  // observed pin
  input wire logic refoutPin,
  // cycles per period and high time
  output int period,
  output int highTime
);
  int cnt = 0;
  int hc = 0;
  logic prev = 1'b0;
  initial period = 0;
  initial highTime = 0;
  // measure the pin like a clocked load
  always @(posedge clk_sys) begin
    prev <= refoutPin;
    cnt <= cnt + 1;
    hc <= refoutPin ? hc + 1 : hc;
    if (refoutPin && !prev) begin
      period <= cnt;
      cnt <= 1;
      hc <= 1;
    end
    if (!refoutPin && prev) highTime <= hc;
  end
endmodule : ucg_ref_sink

// ---- testbench/ucg_clock_ctrl_sva.sv ----
`timescale 1ns/100ps
module ucg_clock_ctrl_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  // state
  input wire logic oscTick,
  input wire logic usbEnable,
  input wire logic [2:0] oscMode,
  input wire logic configLock,
  // results
  input wire logic pllRefTick,
  input wire logic usbClkRun,
  input wire logic [5:0] sysClkMhz,
  input wire logic [4:0] sysDivRatio,
  input wire logic [2:0] nextOscSelect,
  input wire logic refoutPin,
  input wire logic refoutPinOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  oe_write_a: assert property (
    psel && penable && pwrite && paddr == 12'h000 && pstrb[1]
    |=> refoutPinOe == $past(pwdata[15])) else $error("enable bit not on pin enable");
  off_low_a: assert property (!refoutPinOe |=> !refoutPin)
    else $error("pin high while disabled");
  rsvd_zero_a: assert property (
    psel && penable && !pwrite && paddr == 12'h000
    |-> prdata[31:16] == 16'h0000 && !prdata[14] && prdata[7:0] == 8'h00)
    else $error("reserved bits read nonzero");
  usb_on_a: assert property (
    usbEnable && oscMode inside {3'h2, 3'h3, 3'h4} |=> usbClkRun)
    else $error("usb clock missing");
  usb_off_a: assert property (
    !usbEnable || !(oscMode inside {3'h2, 3'h3, 3'h4}) |=> !usbClkRun)
    else $error("usb clock in wrong mode");
  sys_rate_a: assert property (
    !$past(sys_rst) |-> int'(sysClkMhz) * int'(sysDivRatio) == 96)
    else $error("system rate and ratio disagree");
  next_osc_select_lock_a: assert property (
    configLock && psel && penable && pwrite && paddr == 12'h004
    |=> $stable(nextOscSelect)) else $error("locked oscillator select changed");
  pre_tick_a: assert property (pllRefTick |-> $past(oscTick))
    else $error("reference tick without oscillator tick");
endmodule : ucg_clock_ctrl_sva
bind ucg_clock_ctrl ucg_clock_ctrl_sva u_sva (.clk_sys, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .oscTick, .usbEnable, .oscMode,
  .configLock, .pllRefTick, .usbClkRun, .sysClkMhz, .sysDivRatio, .nextOscSelect,
  .refoutPin, .refoutPinOe);

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import ucg_pkg::*;
  // dut inputs
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic oscTick = 1'b1, sysTick = 1'b0, usbEnable = 1'b0, sleepMode = 1'b0;
  logic configLock = 1'b0, primaryOscKeepOn = 1'b0;
  logic [2:0] oscMode = 3'h0;
  // dut outputs
  logic [31:0] prdata, rd;
  logic pready, pslverr, pllRefTick, usbClkRun, refoutPin, refoutPinOe, err, h, oscOn;
  logic [5:0] sysClkMhz;
  logic [4:0] sysDivRatio;
  logic [2:0] nextOscSelect;
  int period, highTime, fails = 0, numChecks = 0, cyc = 0;
  // clock and a system tick every second cycle
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) sysTick <= ~sysTick;
  ucg_clock_ctrl dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .oscTick, .sysTick, .oscMode, .usbEnable,
    .sleepMode, .configLock, .primaryOscKeepOn, .pllRefTick, .usbClkRun, .sysClkMhz,
    .sysDivRatio, .nextOscSelect, .primaryOscRunInSleep(oscOn), .refoutPin, .refoutPinOe);
  ucg_ref_sink sink (.clk_sys, .refoutPin, .period, .highTime);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    numChecks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk
  task automatic run(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // pin seen high at all over eight cycles
  task automatic seen();
    h = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      h = h | refoutPin;
    end
  endtask : seen
  task automatic t_regs();
    apb(1'b0, OFS_REFCON, 32'h0);
    chk("refcon reset", 32'h0, rd);
    apb(1'b1, OFS_REFCON, 32'hFFFF_FFFF);
    apb(1'b0, OFS_REFCON, 32'h0);
    chk("refcon bits", 32'h0000_BF00, rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask : t_regs
  task automatic t_div();
    for (int n = 1; n <= 4; n++) begin
      apb(1'b1, OFS_REFCON, 32'h9000 | (n << 8));
      run((3 << n) + 6);
      chk("ref period", 1 << n, period);
      chk("ref high", 1 << (n - 1), highTime);
      chk("ref oe", 32'h1, {31'h0, refoutPinOe});
    end
    apb(1'b1, OFS_REFCON, 32'h8100);
    run(20);
    chk("sys source period", 4, period);
    // divisor zero passes the base clock through
    apb(1'b1, OFS_REFCON, 32'h8000);
    run(10);
    chk("pass period", 2, period);
  endtask : t_div
  task automatic t_sleep();
    apb(1'b1, OFS_REFCON, 32'h9100);
    sleepMode <= 1'b1;
    run(3);
    seen();
    chk("sleep stopped", 32'h0, {31'h0, h});
    chk("osc in sleep", 32'h0, {31'h0, oscOn});
    apb(1'b1, OFS_REFCON, 32'hB100);
    seen();
    chk("sleep running", 32'h1, {31'h0, h});
    chk("osc kept", 32'h1, {31'h0, oscOn});
    // keep-on bit alone holds the oscillator in sleep
    apb(1'b1, OFS_REFCON, 32'h9100);
    primaryOscKeepOn <= 1'b1;
    run(1);
    chk("osc keep bit", 32'h1, {31'h0, oscOn});
    primaryOscKeepOn <= 1'b0;
    sleepMode <= 1'b0;
    apb(1'b1, OFS_REFCON, 32'h0);
    run(2);
    seen();
    chk("disabled pin", 32'h0, {31'h0, h | refoutPinOe});
  endtask : t_sleep
  task automatic t_clk();
    int fac [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    int k;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, OFS_PLLCFG, c);
      do @(posedge clk_sys); while (pllRefTick !== 1'b1);
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (pllRefTick !== 1'b1);
      chk("prescale", fac[c], k);
    end
    // no oscillator ticks, no reference ticks
    oscTick <= 1'b0;
    run(2);
    h = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      h = h | pllRefTick;
    end
    chk("prescale idle", 32'h0, {31'h0, h});
    oscTick <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_PLLCFG, c << 4);
      run(3);
      chk("sys mhz", 32 >> c, {26'h0, sysClkMhz});
      chk("sys ratio", 3 << c, {27'h0, sysDivRatio});
    end
    // status: 4 MHz, ratio 24, prescale factor 1, all flags low
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status word", 32'h0118_0400, rd);
  endtask : t_clk
  task automatic t_usb();
    usbEnable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      oscMode <= m[2:0];
      run(3);
      chk("usb run", (m >= 2 && m <= 4), {31'h0, usbClkRun});
    end
    usbEnable <= 1'b0;
    configLock <= 1'b1;
    apb(1'b1, OFS_PLLCFG, 32'h0500);
    run(2);
    chk("locked osc", 32'h0, {29'h0, nextOscSelect});
    configLock <= 1'b0;
    apb(1'b1, OFS_PLLCFG, 32'h0500);
    run(2);
    chk("unlocked osc", 32'h5, {29'h0, nextOscSelect});
  endtask : t_usb
  // main sequence
  initial begin
    run(8);
    sys_rst <= 1'b0;
    t_regs();
    t_div();
    t_sleep();
    t_clk();
    t_usb();
    report_and_stop();
  end
endmodule : tb_top
